// ### hdl/enclave_access_checker.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module enclave_access_checker (
   input wire logic REF_CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Access request from core
   input wire logic ACC_VALID,
   input wire enclave_pkg::access_kind_type ACC_KIND,
   input wire logic [enclave_pkg::ADDR_W-1:0] ACC_ADDR,
   input wire logic [enclave_pkg::ADDR_W-1:0] ACC_LAST_ADDR,
   input wire logic ACC_EXPLICIT,
   input wire logic ACC_BASE_FAULT,
   // Page lookup for first and last byte, index 0 and 1
   input wire logic [1:0] PAGE_IN_POOL,
   input wire logic [1:0] PAGE_VALID,
   input wire enclave_pkg::page_kind_type PAGE_KIND_0,
   input wire enclave_pkg::page_kind_type PAGE_KIND_1,
   input wire logic [2*enclave_pkg::EID_W-1:0] PAGE_OWNER,
   input wire logic [2*enclave_pkg::ADDR_W-1:0] PAGE_LINADDR,
   input wire logic [5:0] PAGE_PERM,
   input wire logic [5:0] PAGE_STATE,
   input wire logic [31:0] READ_DATA_IN,
   // Mode change
   input wire enclave_pkg::mode_op_type MODE_OP,
   input wire logic [3:0] SEG_USABLE,
   input wire logic [4*enclave_pkg::SEG_W-1:0] SEG_BASE,
   input wire logic [enclave_pkg::SEG_W-1:0] FS_IN,
   input wire logic [enclave_pkg::SEG_W-1:0] GS_IN,
   input wire logic [enclave_pkg::SEG_W-1:0] TCS_FS,
   input wire logic [enclave_pkg::SEG_W-1:0] TCS_GS,
   input wire logic [enclave_pkg::SEG_W-1:0] FRAME_FS,
   input wire logic [enclave_pkg::SEG_W-1:0] FRAME_GS,
   // Results
   output logic CHECK_DONE,
   output enclave_pkg::fault_kind_type FAULT_KIND,
   output logic [enclave_pkg::ERR_W-1:0] FAULT_CODE,
   output logic WRITE_ALLOW,
   output logic [31:0] READ_DATA_OUT,
   output logic IN_ENCLAVE,
   output logic MODE_DONE,
   output logic MODE_FAULT,
   output logic FS_LOAD,
   output logic [enclave_pkg::SEG_W-1:0] FS_OUT,
   output logic [enclave_pkg::SEG_W-1:0] GS_OUT,
   output logic FRAME_WRITE,
   output logic [enclave_pkg::SEG_W-1:0] FRAME_FS_OUT,
   output logic [enclave_pkg::SEG_W-1:0] FRAME_GS_OUT
);
   import enclave_pkg::*;

   // ------
   // Registers
   // ------
   logic [31:0] ctrl_reg, ctrl_next;
   logic [ADDR_W-1:0] range_base_reg, range_base_next;
   logic [ADDR_W-1:0] range_limit_reg, range_limit_next;
   logic [EID_W-1:0] enclave_id_reg, enclave_id_next;
   logic in_enclave_reg, in_enclave_next;
   logic [ERR_W-1:0] last_code_reg, last_code_next;
   logic [ADDR_W-1:0] last_addr_reg, last_addr_next;
   logic [SEG_W-1:0] saved_fs_reg, saved_fs_next;
   logic [SEG_W-1:0] saved_gs_reg, saved_gs_next;
   logic [SEG_W-1:0] enc_fs_reg, enc_fs_next;
   logic [SEG_W-1:0] enc_gs_reg, enc_gs_next;
   logic [31:0] prdata_reg, prdata_next;
   logic done_reg, done_next;
   fault_kind_type kind_reg, kind_next;
   logic [ERR_W-1:0] code_reg, code_next;
   logic wallow_reg, wallow_next;
   logic [31:0] rdata_reg, rdata_next;
   logic mdone_reg, mdone_next;
   logic mfault_reg, mfault_next;
   logic fsload_reg, fsload_next;
   logic [SEG_W-1:0] fs_reg, fs_next;
   logic [SEG_W-1:0] gs_reg, gs_next;
   logic fwrite_reg, fwrite_next;
   logic [SEG_W-1:0] ffs_reg, ffs_next;
   logic [SEG_W-1:0] fgs_reg, fgs_next;

   // ------
   // Per-part checks
   // ------
   logic [1:0] part_in_range;
   logic [1:0] part_pf;
   logic [ADDR_W-1:0] part_addr [2];
   page_kind_type part_kind [2];
   logic [3:0] seg_bad;
   logic fetch_gp;

   assign part_addr[0] = ACC_ADDR;
   assign part_addr[1] = ACC_LAST_ADDR;
   assign part_kind[0] = PAGE_KIND_0;
   assign part_kind[1] = PAGE_KIND_1;

   // Straddling access: first and last bytes checked on their own
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_part
         logic regular;
         logic [2:0] perm;
         logic perm_ok;
         assign part_in_range[g] = (part_addr[g] >= range_base_reg) &&
            (part_addr[g] <= range_limit_reg);
         assign regular = (part_kind[g] == REGULAR_PAGE_TYPE);
         assign perm = regular ? PAGE_PERM[3*g +: 3] : 3'h0;
         always_comb begin
            case (ACC_KIND)
               ACC_WRITE: perm_ok = perm[1];
               ACC_FETCH: perm_ok = perm[2];
               default: perm_ok = perm[0];
            endcase
         end
         always_comb begin
            part_pf[g] = 1'b0;
            if (in_enclave_reg && part_in_range[g]) begin
               if (!PAGE_IN_POOL[g] || !PAGE_VALID[g])
                  part_pf[g] = 1'b1;
               else if (PAGE_OWNER[EID_W*g +: EID_W] != enclave_id_reg)
                  part_pf[g] = 1'b1;
               else if (!regular)
                  part_pf[g] = 1'b1;
               else if (PAGE_LINADDR[ADDR_W*g+PAGE_SHIFT +: ADDR_W-PAGE_SHIFT] !=
                        part_addr[g][ADDR_W-1:PAGE_SHIFT])
                  part_pf[g] = 1'b1;
               else if (|PAGE_STATE[3*g +: 3])
                  part_pf[g] = 1'b1;
               else if (!perm_ok)
                  part_pf[g] = 1'b1;
            end
         end
      end
      for (g = 0; g < 4; g++) begin : g_seg
         assign seg_bad[g] = SEG_USABLE[g] && (SEG_BASE[SEG_W*g +: SEG_W] != '0);
      end
   endgenerate

   // Any out-of-range byte of an enclave fetch
   assign fetch_gp = in_enclave_reg && (ACC_KIND == ACC_FETCH) &&
      !(&part_in_range);

   // ------
   // Next state
   // ------
   always_comb begin
      logic apb_wr;
      logic apb_rd;
      logic pool_hit;
      logic entering;
      apb_wr = PSEL && PENABLE && PWRITE;
      apb_rd = PSEL && !PENABLE && !PWRITE;
      pool_hit = PAGE_IN_POOL[0] || PAGE_IN_POOL[1];
      entering = (MODE_OP == OP_ENTER) || (MODE_OP == OP_RESUME);
      ctrl_next = ctrl_reg;
      range_base_next = range_base_reg;
      range_limit_next = range_limit_reg;
      enclave_id_next = enclave_id_reg;
      in_enclave_next = in_enclave_reg;
      last_code_next = last_code_reg;
      last_addr_next = last_addr_reg;
      saved_fs_next = saved_fs_reg;
      saved_gs_next = saved_gs_reg;
      enc_fs_next = enc_fs_reg;
      enc_gs_next = enc_gs_reg;
      prdata_next = prdata_reg;
      done_next = 1'b0;
      kind_next = kind_reg;
      code_next = code_reg;
      wallow_next = 1'b0;
      rdata_next = rdata_reg;
      mdone_next = 1'b0;
      mfault_next = 1'b0;
      fsload_next = 1'b0;
      fs_next = fs_reg;
      gs_next = gs_reg;
      fwrite_next = 1'b0;
      ffs_next = ffs_reg;
      fgs_next = fgs_reg;

      // APB registers; range and identity change only outside enclave
      if (apb_wr) begin
         case (PADDR)
            CTRL_OFFSET: ctrl_next = PWDATA;
            RANGE_BASE_OFFSET: if (!in_enclave_reg) range_base_next = PWDATA;
            RANGE_LIMIT_OFFSET: if (!in_enclave_reg) range_limit_next = PWDATA;
            ENCLAVE_ID_OFFSET: if (!in_enclave_reg) enclave_id_next = PWDATA[EID_W-1:0];
            default: ;
         endcase
      end
      if (apb_rd) begin
         case (PADDR)
            CTRL_OFFSET: prdata_next = ctrl_reg;
            RANGE_BASE_OFFSET: prdata_next = range_base_reg;
            RANGE_LIMIT_OFFSET: prdata_next = range_limit_reg;
            ENCLAVE_ID_OFFSET: prdata_next = {{(32-EID_W){1'b0}}, enclave_id_reg};
            STATUS_OFFSET: prdata_next = {31'h0, in_enclave_reg};
            FAULT_CODE_OFFSET: prdata_next = {{(32-ERR_W){1'b0}}, last_code_reg};
            FAULT_ADDR_OFFSET: prdata_next = last_addr_reg;
            SAVED_FS_OFFSET: prdata_next = saved_fs_reg;
            SAVED_GS_OFFSET: prdata_next = saved_gs_reg;
            STATE_FS_OFFSET: prdata_next = enc_fs_reg;
            STATE_GS_OFFSET: prdata_next = enc_gs_reg;
            default: prdata_next = ZERO_RESET;
         endcase
      end

      // Access check: one answer per request, GP ahead of PF
      if (ACC_VALID) begin
         done_next = 1'b1;
         kind_next = FAULT_NONE;
         code_next = '0;
         rdata_next = READ_DATA_IN;
         if (ACC_BASE_FAULT) begin
            // Segmentation or paging fault wins, explicit operands too
            kind_next = FAULT_GP;
            code_next = GP_ERROR_CODE;
         end else if (fetch_gp) begin
            kind_next = FAULT_GP;
            code_next = GP_ERROR_CODE;
         end else if (|part_pf) begin
            kind_next = FAULT_PF;
            code_next = '0;
            code_next[FC_ENCLAVE_BIT] = 1'b1;
            code_next[FC_PRESENT_BIT] = 1'b1;
            code_next[FC_WRITE_BIT] = (ACC_KIND == ACC_WRITE);
            code_next[FC_FETCH_BIT] = (ACC_KIND == ACC_FETCH);
         end else if (!in_enclave_reg && pool_hit) begin
            // Outside code gets masked data and no write, no fault
            if (ctrl_reg[CTRL_READ_MASK_BIT])
               rdata_next = READ_MASK_VALUE;
         end
         wallow_next = (kind_next == FAULT_NONE) && (ACC_KIND == ACC_WRITE) &&
            (in_enclave_reg || !pool_hit);
         if (kind_next != FAULT_NONE) begin
            last_code_next = code_next;
            last_addr_next = ACC_ADDR;
         end
      end

      // Mode changes
      if (MODE_OP != OP_NONE) begin
         mdone_next = 1'b1;
         if (entering && !in_enclave_reg) begin
            if (|seg_bad) begin
               mfault_next = 1'b1;
            end else begin
               in_enclave_next = 1'b1;
               saved_fs_next = FS_IN;
               saved_gs_next = GS_IN;
               fsload_next = 1'b1;
               fs_next = (MODE_OP == OP_RESUME) ? FRAME_FS : TCS_FS;
               gs_next = (MODE_OP == OP_RESUME) ? FRAME_GS : TCS_GS;
               enc_fs_next = fs_next;
               enc_gs_next = gs_next;
            end
         end else if ((MODE_OP == OP_EXIT || MODE_OP == OP_ASYNC_EXIT) && in_enclave_reg) begin
            in_enclave_next = 1'b0;
            fsload_next = 1'b1;
            fs_next = saved_fs_reg;
            gs_next = saved_gs_reg;
            if (MODE_OP == OP_ASYNC_EXIT) begin
               fwrite_next = 1'b1;
               ffs_next = FS_IN;
               fgs_next = GS_IN;
            end
         end else begin
            // Wrong mode for this operation; no transition
            mfault_next = 1'b1;
         end
      end
   end

   // ------
   // Register update
   // ------
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ctrl_reg <= CTRL_RESET;
         range_base_reg <= ZERO_RESET;
         range_limit_reg <= ZERO_RESET;
         enclave_id_reg <= '0;
         in_enclave_reg <= 1'b0;
         last_code_reg <= '0;
         last_addr_reg <= '0;
         saved_fs_reg <= '0;
         saved_gs_reg <= '0;
         enc_fs_reg <= '0;
         enc_gs_reg <= '0;
         prdata_reg <= '0;
         done_reg <= 1'b0;
         kind_reg <= FAULT_NONE;
         code_reg <= '0;
         wallow_reg <= 1'b0;
         rdata_reg <= '0;
         mdone_reg <= 1'b0;
         mfault_reg <= 1'b0;
         fsload_reg <= 1'b0;
         fs_reg <= '0;
         gs_reg <= '0;
         fwrite_reg <= 1'b0;
         ffs_reg <= '0;
         fgs_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         range_base_reg <= range_base_next;
         range_limit_reg <= range_limit_next;
         enclave_id_reg <= enclave_id_next;
         in_enclave_reg <= in_enclave_next;
         last_code_reg <= last_code_next;
         last_addr_reg <= last_addr_next;
         saved_fs_reg <= saved_fs_next;
         saved_gs_reg <= saved_gs_next;
         enc_fs_reg <= enc_fs_next;
         enc_gs_reg <= enc_gs_next;
         prdata_reg <= prdata_next;
         done_reg <= done_next;
         kind_reg <= kind_next;
         code_reg <= code_next;
         wallow_reg <= wallow_next;
         rdata_reg <= rdata_next;
         mdone_reg <= mdone_next;
         mfault_reg <= mfault_next;
         fsload_reg <= fsload_next;
         fs_reg <= fs_next;
         gs_reg <= gs_next;
         fwrite_reg <= fwrite_next;
         ffs_reg <= ffs_next;
         fgs_reg <= fgs_next;
      end
   end

   // ------
   // Outputs
   // ------
   assign PRDATA = prdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign CHECK_DONE = done_reg;
   assign FAULT_KIND = kind_reg;
   assign FAULT_CODE = code_reg;
   assign WRITE_ALLOW = wallow_reg;
   assign READ_DATA_OUT = rdata_reg;
   assign IN_ENCLAVE = in_enclave_reg;
   assign MODE_DONE = mdone_reg;
   assign MODE_FAULT = mfault_reg;
   assign FS_LOAD = fsload_reg;
   assign FS_OUT = fs_reg;
   assign GS_OUT = gs_reg;
   assign FRAME_WRITE = fwrite_reg;
   assign FRAME_FS_OUT = ffs_reg;
   assign FRAME_GS_OUT = fgs_reg;

endmodule // enclave_access_checker

// ### hdl/enclave_pkg.sv
package enclave_pkg;
   // ------
   // Widths
   // ------
   localparam int ADDR_W = 32;
   localparam int SEG_W = 32;
   localparam int EID_W = 8;
   localparam int PAGE_SHIFT = 12;
   localparam int ERR_W = 16;
   // ------
   // APB register map
   // ------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] RANGE_BASE_OFFSET = 8'h04;
   localparam logic [7:0] RANGE_LIMIT_OFFSET = 8'h08;
   localparam logic [7:0] ENCLAVE_ID_OFFSET = 8'h0C;
   localparam logic [7:0] STATUS_OFFSET = 8'h10;
   localparam logic [7:0] FAULT_CODE_OFFSET = 8'h14;
   localparam logic [7:0] FAULT_ADDR_OFFSET = 8'h18;
   localparam logic [7:0] SAVED_FS_OFFSET = 8'h1C;
   localparam logic [7:0] SAVED_GS_OFFSET = 8'h20;
   localparam logic [7:0] STATE_FS_OFFSET = 8'h24;
   localparam logic [7:0] STATE_GS_OFFSET = 8'h28;
   localparam int CTRL_READ_MASK_BIT = 0;
   localparam logic [31:0] READ_MASK_VALUE = 32'hFFFFFFFF;
   localparam logic [31:0] CTRL_RESET = 32'h00000001;
   localparam logic [31:0] ZERO_RESET = 32'h00000000;
   // ------
   // Fault code fields
   // ------
   localparam int FC_PRESENT_BIT = 0;
   localparam int FC_WRITE_BIT = 1;
   localparam int FC_FETCH_BIT = 4;
   localparam int FC_ENCLAVE_BIT = 15;
   localparam logic [ERR_W-1:0] GP_ERROR_CODE = 16'h0000;
   // ------
   // Page types and encodings
   // ------
   typedef enum logic [2:0] {
      ENCLAVE_CONTROL_PAGE_TYPE = 3'h0,
      THREAD_CONTROL_PAGE_TYPE = 3'h1,
      REGULAR_PAGE_TYPE = 3'h2,
      VERSION_ARRAY_PAGE_TYPE = 3'h3,
      TRIMMED_PAGE_TYPE = 3'h4
   } page_kind_type;
   typedef enum logic [1:0] {
      ACC_READ = 2'h0,
      ACC_WRITE = 2'h1,
      ACC_FETCH = 2'h2
   } access_kind_type;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_ENTER = 3'h1,
      OP_RESUME = 3'h2,
      OP_EXIT = 3'h3,
      OP_ASYNC_EXIT = 3'h4
   } mode_op_type;
   typedef enum logic [1:0] {
      FAULT_NONE = 2'h0,
      FAULT_GP = 2'h1,
      FAULT_PF = 2'h2
   } fault_kind_type;
endpackage

// ### sim/enclave_checker_sva.sv
`timescale 1ns/100ps
module enclave_checker_sva (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic ACC_VALID,
   input wire enclave_pkg::access_kind_type ACC_KIND,
   input wire logic ACC_BASE_FAULT,
   input wire logic [1:0] PAGE_IN_POOL,
   input wire enclave_pkg::mode_op_type MODE_OP,
   input wire logic [3:0] SEG_USABLE,
   input wire logic [127:0] SEG_BASE,
   input wire logic [31:0] FS_IN,
   input wire logic [31:0] TCS_FS,
   input wire logic [31:0] TCS_GS,
   input wire logic CHECK_DONE,
   input wire enclave_pkg::fault_kind_type FAULT_KIND,
   input wire logic [15:0] FAULT_CODE,
   input wire logic WRITE_ALLOW,
   input wire logic IN_ENCLAVE,
   input wire logic MODE_FAULT,
   input wire logic FS_LOAD,
   input wire logic [31:0] FS_OUT,
   input wire logic [31:0] GS_OUT,
   input wire logic FRAME_WRITE,
   input wire logic [31:0] FRAME_FS_OUT
);
   import enclave_pkg::*;
   // ------
   // Properties
   // ------
   logic seg_bad;
   assign seg_bad = |(SEG_USABLE & {|SEG_BASE[127:96], |SEG_BASE[95:64],
                                    |SEG_BASE[63:32], |SEG_BASE[31:0]});
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   chk_access_answer: assert property (ACC_VALID |=> CHECK_DONE)
      else $error("access got no answer");
   chk_base_gp: assert property (ACC_VALID && ACC_BASE_FAULT |=>
      FAULT_KIND == FAULT_GP && FAULT_CODE == GP_ERROR_CODE) else $error("base fault not GP");
   chk_pf_code: assert property (ACC_VALID ##1 (CHECK_DONE && FAULT_KIND == FAULT_PF)
      |-> FAULT_CODE[FC_ENCLAVE_BIT] && FAULT_CODE[FC_WRITE_BIT] == ($past(ACC_KIND) == ACC_WRITE))
      else $error("page fault code wrong");
   chk_fault_blocks: assert property (CHECK_DONE && FAULT_KIND != FAULT_NONE |->
      !WRITE_ALLOW) else $error("faulting write allowed");
   chk_outside_drop: assert property (ACC_VALID && !IN_ENCLAVE && MODE_OP == OP_NONE &&
      PAGE_IN_POOL[0] && !ACC_BASE_FAULT |=> !WRITE_ALLOW && FAULT_KIND == FAULT_NONE)
      else $error("outside pool access not dropped");
   chk_entry_source: assert property ($rose(IN_ENCLAVE) |->
      $past(MODE_OP) == OP_ENTER || $past(MODE_OP) == OP_RESUME) else $error("bad entry");
   chk_seg_base: assert property ((MODE_OP == OP_ENTER || MODE_OP == OP_RESUME) &&
      !IN_ENCLAVE && seg_bad |=> MODE_FAULT && !IN_ENCLAVE) else $error("segment base missed");
   chk_enter_load: assert property (MODE_OP == OP_ENTER && !IN_ENCLAVE ##1 !MODE_FAULT
      |-> FS_LOAD && FS_OUT == $past(TCS_FS) && GS_OUT == $past(TCS_GS))
      else $error("entry load wrong");
   chk_async_frame: assert property (MODE_OP == OP_ASYNC_EXIT && IN_ENCLAVE |=>
      FRAME_WRITE && FRAME_FS_OUT == $past(FS_IN) && !IN_ENCLAVE) else $error("frame save wrong");
   chk_exit_restore: assert property (MODE_OP == OP_EXIT && IN_ENCLAVE |=>
      FS_LOAD && !IN_ENCLAVE) else $error("exit restore missing");
endmodule // enclave_checker_sva
bind enclave_access_checker enclave_checker_sva i_enclave_checker_sva (.REF_CLK, .RST_N,
   .ACC_VALID, .ACC_KIND, .ACC_BASE_FAULT, .PAGE_IN_POOL, .MODE_OP, .SEG_USABLE, .SEG_BASE,
   .FS_IN, .TCS_FS, .TCS_GS, .CHECK_DONE, .FAULT_KIND, .FAULT_CODE, .WRITE_ALLOW, .IN_ENCLAVE,
   .MODE_FAULT, .FS_LOAD, .FS_OUT, .GS_OUT, .FRAME_WRITE, .FRAME_FS_OUT);

// ### sim/page_pool_model.sv
`timescale 1ns/100ps
module page_pool_model #(
   parameter logic [7:0] OWNER_DEF = 8'h05
) (
   input wire logic [31:0] addr_a,
   input wire logic [31:0] addr_b,
   output logic [1:0] in_pool,
   output logic [1:0] valid,
   output enclave_pkg::page_kind_type kind_a,
   output enclave_pkg::page_kind_type kind_b,
   output logic [15:0] owner,
   output logic [63:0] linaddr,
   output logic [5:0] perm,
   output logic [5:0] state,
   output logic [31:0] rdata
);
   import enclave_pkg::*;
   // ------
   // Page table, 16 pages at the pool window
   // ------
   page_kind_type kind_tab [16];
   logic [7:0] owner_tab [16];
   logic [2:0] perm_tab [16];
   logic [2:0] state_tab [16];
   logic lin_off [16];
   logic [31:0] a;
   logic [3:0] i;
   initial begin
      for (int p = 0; p < 16; p++) begin
         kind_tab[p] = REGULAR_PAGE_TYPE;
         owner_tab[p] = OWNER_DEF;
         perm_tab[p] = 3'h7;
         state_tab[p] = 3'h0;
         lin_off[p] = 1'b0;
      end
   end
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         a = p ? addr_b : addr_a;
         i = a[15:12];
         in_pool[p] = a[31:16] == 16'h1000;
         owner[p*8 +: 8] = owner_tab[i];
         linaddr[p*32 +: 32] = {a[31:12] + 20'(lin_off[i]), 12'h000};
         perm[p*3 +: 3] = perm_tab[i];
         state[p*3 +: 3] = state_tab[i];
      end
      kind_a = kind_tab[addr_a[15:12]];
      kind_b = kind_tab[addr_b[15:12]];
      valid = in_pool;
      // Inverted address so stale data never passes for a fresh read
      rdata = ~addr_a;
   end
endmodule // page_pool_model

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import enclave_pkg::*;
   // ------
   // Signals
   // ------
   localparam logic [31:0] BASE = 32'h1000_0000, LIMIT = 32'h1FFF_FFFF;
   localparam logic [31:0] PG2 = 32'h1000_2A40, OUTA = 32'h4000_0000;
   localparam logic [7:0] EID = 8'h05;
   logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic ACC_VALID = 0, ACC_EXPLICIT = 0, ACC_BASE_FAULT = 0;
   logic [7:0] PADDR = '0;
   logic [31:0] PWDATA = '0, ACC_ADDR = '0, ACC_LAST_ADDR = '0, FS_IN, GS_IN;
   logic [31:0] TCS_FS, TCS_GS, FRAME_FS, FRAME_GS, fs0, gs0, a;
   access_kind_type ACC_KIND = ACC_READ;
   mode_op_type MODE_OP = OP_NONE;
   logic [3:0] SEG_USABLE = '0;
   logic [127:0] SEG_BASE = '0;
   logic [1:0] PAGE_IN_POOL, PAGE_VALID;
   page_kind_type PAGE_KIND_0, PAGE_KIND_1;
   logic [15:0] PAGE_OWNER, FAULT_CODE;
   logic [63:0] PAGE_LINADDR;
   logic [5:0] PAGE_PERM, PAGE_STATE;
   logic [31:0] READ_DATA_IN, PRDATA, READ_DATA_OUT, FS_OUT, GS_OUT, FRAME_FS_OUT, FRAME_GS_OUT;
   logic PREADY, PSLVERR, CHECK_DONE, WRITE_ALLOW, IN_ENCLAVE, MODE_DONE, MODE_FAULT;
   logic FS_LOAD, FRAME_WRITE;
   fault_kind_type FAULT_KIND;
   logic [51:0] eq[$], e;
   logic [67:0] mq[$], m;
   page_kind_type kl[4] = '{ENCLAVE_CONTROL_PAGE_TYPE, THREAD_CONTROL_PAGE_TYPE,
                            VERSION_ARRAY_PAGE_TYPE, TRIMMED_PAGE_TYPE};
   int err_total = 0, n_tests = 0, cyc = 0;
   always #12.5 REF_CLK = ~REF_CLK;
   enclave_access_checker i_enclave_access_checker (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .ACC_VALID, .ACC_KIND, .ACC_ADDR,
      .ACC_LAST_ADDR, .ACC_EXPLICIT, .ACC_BASE_FAULT, .PAGE_IN_POOL, .PAGE_VALID, .PAGE_KIND_0,
      .PAGE_KIND_1, .PAGE_OWNER, .PAGE_LINADDR, .PAGE_PERM, .PAGE_STATE, .READ_DATA_IN,
      .MODE_OP, .SEG_USABLE, .SEG_BASE, .FS_IN, .GS_IN, .TCS_FS, .TCS_GS, .FRAME_FS, .FRAME_GS,
      .CHECK_DONE, .FAULT_KIND, .FAULT_CODE, .WRITE_ALLOW, .READ_DATA_OUT, .IN_ENCLAVE,
      .MODE_DONE, .MODE_FAULT, .FS_LOAD, .FS_OUT, .GS_OUT, .FRAME_WRITE, .FRAME_FS_OUT,
      .FRAME_GS_OUT);
   page_pool_model #(.OWNER_DEF(EID)) i_page_pool_model (.addr_a(ACC_ADDR),
      .addr_b(ACC_LAST_ADDR), .in_pool(PAGE_IN_POOL), .valid(PAGE_VALID), .kind_a(PAGE_KIND_0),
      .kind_b(PAGE_KIND_1), .owner(PAGE_OWNER), .linaddr(PAGE_LINADDR), .perm(PAGE_PERM),
      .state(PAGE_STATE), .rdata(READ_DATA_IN));
   // ------
   // Tasks
   // ------
   task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
      n_tests++;
      if (s !== x) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic [31:0] x);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= ad;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do @(posedge REF_CLK); while (PREADY !== 1'b1);
      if (!w) chk("prdata", {PSLVERR, PRDATA}, {1'b0, x});
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge REF_CLK);
   endtask
   function automatic logic [51:0] ex(fault_kind_type f, access_kind_type k, logic wa,
                                      logic [31:0] rd);
      logic [15:0] c;
      c = 16'h0000;
      if (f == FAULT_PF) begin
         c[FC_ENCLAVE_BIT] = 1'b1;
         c[FC_PRESENT_BIT] = 1'b1;
         c[FC_WRITE_BIT] = k == ACC_WRITE;
         c[FC_FETCH_BIT] = k == ACC_FETCH;
      end
      return {f == FAULT_NONE && k == ACC_READ, f, c, wa, rd};
   endfunction
   // Valid held between calls for back-to-back checks
   task automatic acc(access_kind_type k, logic [31:0] ad, logic [31:0] l, logic [51:0] x);
      ACC_VALID <= 1'b1;
      ACC_KIND <= k;
      ACC_ADDR <= ad;
      ACC_LAST_ADDR <= l;
      eq.push_back(x);
      @(posedge REF_CLK);
   endtask
   task automatic idle();
      ACC_VALID <= 1'b0;
      ACC_BASE_FAULT <= 1'b0;
      repeat (2) @(posedge REF_CLK);
   endtask
   task automatic pf(access_kind_type k, page_kind_type t, logic [7:0] o, logic [2:0] p,
                     logic [2:0] s, logic f, logic ok);
      i_page_pool_model.kind_tab[2] <= t;
      i_page_pool_model.owner_tab[2] <= o;
      i_page_pool_model.perm_tab[2] <= p;
      i_page_pool_model.state_tab[2] <= s;
      i_page_pool_model.lin_off[2] <= f;
      acc(k, PG2, PG2, ex(ok ? FAULT_NONE : FAULT_PF, k, ok && k == ACC_WRITE, ~PG2));
   endtask
   task automatic mode(mode_op_type op, logic [67:0] x);
      MODE_OP <= op;
      mq.push_back(x);
      @(posedge REF_CLK);
      MODE_OP <= OP_NONE;
      repeat (2) @(posedge REF_CLK);
   endtask
   // ------
   // Monitors
   // ------
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
      if (CHECK_DONE === 1'b1) begin
         e = eq.pop_front();
         chk("access", {FAULT_KIND, FAULT_CODE, WRITE_ALLOW}, 64'(e[50:32]));
         if (e[51]) chk("rdata", READ_DATA_OUT, e[31:0]);
      end
      if (MODE_DONE === 1'b1) begin
         m = mq.pop_front();
         chk("mode", {MODE_FAULT, FS_LOAD, FRAME_WRITE, IN_ENCLAVE}, m[67:64]);
         if (m[66]) chk("fsgs", {FS_OUT, GS_OUT}, m[63:0]);
         if (m[65]) chk("frame", {FRAME_FS_OUT, FRAME_GS_OUT}, {TCS_FS, TCS_GS});
      end
   end
   // ------
   // Main sequence
   // ------
   initial begin
      void'($urandom(32'h7652));
      fs0 = $urandom;
      gs0 = $urandom;
      FS_IN = fs0;
      GS_IN = gs0;
      TCS_FS = $urandom;
      TCS_GS = $urandom;
      FRAME_FS = $urandom;
      FRAME_GS = $urandom;
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1'b1;
      @(posedge REF_CLK);
      apb(1'b0, CTRL_OFFSET, '0, CTRL_RESET);
      apb(1'b0, 8'h3C, '0, ZERO_RESET);
      apb(1'b1, RANGE_BASE_OFFSET, BASE, '0);
      apb(1'b1, RANGE_LIMIT_OFFSET, LIMIT, '0);
      apb(1'b1, ENCLAVE_ID_OFFSET, 32'(EID), '0);
      a = BASE | ($urandom & 32'h0000_0FFC);
      acc(ACC_READ, a, a, ex(FAULT_NONE, ACC_READ, 1'b0, READ_MASK_VALUE));
      acc(ACC_WRITE, a, a, ex(FAULT_NONE, ACC_WRITE, 1'b0, '0));
      idle();
      mode(OP_EXIT, {4'b1000, 64'h0});
      for (int s = 0; s < 4; s++) begin
         SEG_USABLE <= 4'hF;
         SEG_BASE <= 128'h1 << (32 * s + 12);
         mode(OP_ENTER, {4'b1000, 64'h0});
      end
      SEG_USABLE <= 4'b1011;
      SEG_BASE <= 128'h1 << 76;
      mode(OP_ENTER, {4'b0101, TCS_FS, TCS_GS});
      FS_IN <= TCS_FS;
      GS_IN <= TCS_GS;
      mode(OP_RESUME, {4'b1001, 64'h0});
      apb(1'b1, RANGE_BASE_OFFSET, '0, '0);
      apb(1'b0, RANGE_BASE_OFFSET, '0, BASE);
      a = BASE + 32'h1000 + ($urandom & 32'h0000_0FFC);
      acc(ACC_READ, a, a, ex(FAULT_NONE, ACC_READ, 1'b0, ~a));
      acc(ACC_WRITE, a, a, ex(FAULT_NONE, ACC_WRITE, 1'b1, '0));
      acc(ACC_READ, BASE + 32'h1_0000, BASE + 32'h1_0000, ex(FAULT_PF, ACC_READ, 0, '0));
      pf(ACC_READ, REGULAR_PAGE_TYPE, EID + 8'h01, 3'h7, 3'h0, 0, 0);
      pf(ACC_WRITE, REGULAR_PAGE_TYPE, EID, 3'h5, 3'h0, 0, 0);
      pf(ACC_READ, REGULAR_PAGE_TYPE, EID, 3'h6, 3'h0, 0, 0);
      pf(ACC_FETCH, REGULAR_PAGE_TYPE, EID, 3'h3, 3'h0, 0, 0);
      pf(ACC_FETCH, REGULAR_PAGE_TYPE, EID, 3'h4, 3'h0, 0, 1);
      pf(ACC_READ, REGULAR_PAGE_TYPE, EID, 3'h7, 3'h0, 1, 0);
      for (int s = 0; s < 3; s++) pf(ACC_READ, REGULAR_PAGE_TYPE, EID, 3'h7, 3'(1 << s), 0, 0);
      foreach (kl[j]) pf(ACC_READ, kl[j], EID, 3'h7, 3'h0, 0, 0);
      acc(ACC_FETCH, OUTA, OUTA, ex(FAULT_GP, ACC_FETCH, 0, '0));
      acc(ACC_FETCH, 32'h1FFF_FFFE, 32'h2000_0001, ex(FAULT_GP, ACC_FETCH, 0, '0));
      acc(ACC_READ, 32'h0FFF_FFFE, BASE + 1, ex(FAULT_NONE, ACC_READ, 0, ~32'h0FFF_FFFE));
      i_page_pool_model.state_tab[0] <= 3'h1;
      acc(ACC_READ, 32'h0FFF_FFFE, BASE + 1, ex(FAULT_PF, ACC_READ, 0, '0));
      ACC_BASE_FAULT <= 1'b1;
      ACC_EXPLICIT <= 1'b1;
      acc(ACC_READ, 32'h0FFF_FFFE, BASE + 1, ex(FAULT_GP, ACC_READ, 0, '0));
      idle();
      mode(OP_ASYNC_EXIT, {4'b0110, fs0, gs0});
      FS_IN <= fs0;
      GS_IN <= gs0;
      mode(OP_RESUME, {4'b0101, FRAME_FS, FRAME_GS});
      mode(OP_EXIT, {4'b0100, fs0, gs0});
      apb(1'b1, CTRL_OFFSET, '0, '0);
      acc(ACC_READ, a, a, ex(FAULT_NONE, ACC_READ, 1'b0, ~a));
      idle();
      repeat (3) @(posedge REF_CLK);
      chk("pending", 64'(eq.size() + mq.size()), 64'h0);
      conclude();
   end
endmodule // tb_top
